// ---- sound_gen_pkg.sv ----
// Purpose: constants shared by the sound generator channel
// Assumes: 32-bit APB register words, one aligned word each
// Notes:   offsets are byte addresses
package sound_gen_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_VOLUME = 8'h00;  // volume_pwm_config
  localparam logic [7:0] OFF_PITCH  = 8'h04;  // pitch_pwm_config
  localparam logic [7:0] OFF_DUR    = 8'h08;  // segment_duration_config
  localparam logic [7:0] OFF_RAMP   = 8'h0C;  // volume_ramp_config
  localparam logic [7:0] OFF_CTRL   = 8'h10;  // enable, format, clock
  localparam logic [7:0] OFF_CAUSE  = 8'h14;  // sticky causes, write 1 clears
  localparam logic [7:0] OFF_STATUS = 8'h18;  // running state, read only
  // field positions
  localparam int PERIOD_LSB  = 0;   // period fields [15:0]
  localparam int HIGH_LSB    = 16;  // high / repeat fields [31:16]
  localparam int FIELD_W     = 16;
  localparam int DIR_LSB     = 16;  // ramp direction [17:16]
  localparam int CTRL_EN     = 0;
  localparam int CTRL_COMB   = 1;
  localparam int CTRL_SEL    = 4;   // [6:4] clock source
  localparam int CTRL_DIV    = 8;   // [15:8] divider
  localparam int SEL_W       = 3;
  localparam int DIV_W       = 8;
  localparam int CAUSE_DONE  = 0;
  localparam int CAUSE_STARV = 1;
  localparam int CAUSE_IF    = 2;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [2:0]  RST_SEL  = 3'h0;
  localparam logic [7:0]  RST_DIV  = 8'h00;
  // clock source code for the master clock input
  localparam logic [2:0]  SEL_MASTER = 3'h4;
  typedef enum logic [1:0] {RAMP_HOLD, RAMP_DOWN, RAMP_UP, RAMP_RSVD} ramp_e;
endpackage : sound_gen_pkg

// ---- pwm_clock_gen.sv ----
// Purpose: interface clock select, divide and gate into a pwm tick
// Assumes: source clock pins are synchronous levels of the system clock
// Notes:   master clock out toggles once per pwm tick
`timescale 1ns/100ps
module pwm_clock_gen
  import sound_gen_pkg::*;
(
  input  wire logic                          clock,
  input  wire logic                          rst,
  input  wire logic [3:0]                    systemClockInputs,
  input  wire logic                          masterClockIn,
  input  wire logic [sound_gen_pkg::SEL_W-1:0] clockSel,
  input  wire logic [sound_gen_pkg::DIV_W-1:0] clockDiv,
  input  wire logic                          gateOpen,
  output logic                               pwmTick,
  output logic                               masterClockOut
);
  logic             srcLevel;
  logic             srcPrev_q;
  logic [DIV_W-1:0] divCnt_q;
  logic             ifEdge;

  // source select and rising edge of the interface clock
  assign srcLevel = (clockSel == SEL_MASTER) ? masterClockIn :
                    (clockSel < SEL_MASTER) ? systemClockInputs[clockSel[1:0]] : 1'b0;
  assign ifEdge   = srcLevel && !srcPrev_q;

  // divider by clockDiv+1, gated into the pwm tick
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      srcPrev_q      <= 1'b0;
      divCnt_q       <= '0;
      pwmTick        <= 1'b0;
      masterClockOut <= 1'b0;
    end else begin
      srcPrev_q <= srcLevel;
      pwmTick   <= 1'b0;
      if (!gateOpen) begin
        divCnt_q       <= '0;
        masterClockOut <= 1'b0;
      end else if (ifEdge) begin
        if (divCnt_q >= clockDiv) begin
          divCnt_q       <= '0;
          pwmTick        <= 1'b1;
          masterClockOut <= !masterClockOut;
        end else begin
          divCnt_q <= divCnt_q + 1'b1;
        end
      end
    end
  end
endmodule : pwm_clock_gen

// ---- pwm_sound_generator.sv ----
// Purpose: one sound generator channel with double-buffered segments
// Assumes: APB slave with one wait state, clock pins synchronous
// Notes:   descriptor counts in pwm ticks, amplitude and tone periods
// Overview of operation
// RQ1: amplitude period is period field plus one
// RQ2: amplitude high lasts high field plus one
// RQ3: tone period is twice period plus one
// RQ4: tone high lasts high field plus one
// RQ5: time period is duration field plus one
// RQ6: segment ends after repeat count plus one
// RQ7: output runs from current copy only
// RQ8: completion copies buffered into current copy
// RQ9: completion pulses trigger, sets done cause
// RQ10: missing buffered descriptor stops the sound
// RQ11: missing descriptor sets the starved cause
// RQ12: late sample pair sets interface underflow
// RQ13: clock from four system or master input
// RQ14: divide, gate, drive out master clock
// RQ15: outputs change only on pwm ticks
// RQ16: separate or combined single line format
// RQ17: ramp register picks hold, down, up
// RQ18: descriptor is four 32-bit registers
// RQ19: step adjusts high time, saturating
// RQ20: outputs low while stopped
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/100ps
module pwm_sound_generator
  import sound_gen_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  systemClockInputs,
  input  wire logic        masterClockIn,
  output logic             masterClockOut,
  output logic             volumePwmOut,
  output logic             pitchPwmOut,
  output logic             segmentDoneTrigger
);
  logic [31:0] bufDesc_q [4];  // buffered copy
  logic [31:0] curDesc_q [4];  // current copy
  logic        bufValid_q;
  logic        enable_q, combined_q, running_q, loadCycle_q;
  logic [SEL_W-1:0] clockSel_q;
  logic [DIV_W-1:0] clockDiv_q;
  logic [2:0]  cause_q;
  logic [15:0] ampCnt_q, effHigh_q, timeCnt_q, nrCnt_q;
  logic [16:0] toneCnt_q;
  logic        pwmTick, wrEn, rdEn, mapped;
  logic        ampWrap, toneWrap, timeWrap, segEnd, start;
  logic [15:0] ampPer, toneHigh, durPer, repCnt, stepAmt;
  logic [16:0] toneLast;
  ramp_e       rampDir;

  // field extraction from the current copy
  function automatic logic [15:0] fieldLo(input logic [31:0] w);
    return w[PERIOD_LSB +: FIELD_W];
  endfunction : fieldLo
  function automatic logic [15:0] fieldHi(input logic [31:0] w);
    return w[HIGH_LSB +: FIELD_W];
  endfunction : fieldHi

  assign ampPer   = fieldLo(curDesc_q[0]);
  assign toneHigh = fieldHi(curDesc_q[1]);
  assign durPer   = fieldLo(curDesc_q[2]);
  assign repCnt   = fieldHi(curDesc_q[2]);
  assign stepAmt  = fieldLo(curDesc_q[3]);
  assign rampDir  = ramp_e'(curDesc_q[3][DIR_LSB +: 2]);
  assign toneLast = {fieldLo(curDesc_q[1]), 1'b1}; // 2*(P+1)-1 RQ3

  // bus decode
  assign wrEn   = psel && penable && pready && pwrite;
  assign rdEn   = psel && penable && !pready && !pwrite;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= OFF_STATUS);

  // clock select, divider and gate
  pwm_clock_gen pwm_clock_gen_inst (  // RQ13 RQ14
    .clock             (clock),
    .rst               (rst),
    .systemClockInputs (systemClockInputs),
    .masterClockIn     (masterClockIn),
    .clockSel          (clockSel_q),
    .clockDiv          (clockDiv_q),
    .gateOpen          (running_q || start),  // opens at start, a tick may hit reload
    .pwmTick           (pwmTick),
    .masterClockOut    (masterClockOut)
  );

  // apb answer: one wait state, error on unmapped word
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= RST_WORD;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (rdEn) begin
        unique case (paddr)
          OFF_VOLUME, OFF_PITCH, OFF_DUR, OFF_RAMP:
            prdata <= bufDesc_q[paddr[3:2]];
          OFF_CTRL:   prdata <= {16'h0000, clockDiv_q, 1'b0, clockSel_q,
                                 2'b00, combined_q, enable_q};
          OFF_CAUSE:  prdata <= {29'h0000_0000, cause_q};
          OFF_STATUS: prdata <= {30'h0000_0000, bufValid_q, running_q};
          default:    prdata <= RST_WORD;
        endcase
      end
    end
  end

  // buffered descriptor: writable at any time, ramp write marks it full
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) bufDesc_q[i] <= RST_WORD;
      bufValid_q <= 1'b0;
    end else begin
      if (wrEn && !pslverr && paddr < OFF_CTRL)
        bufDesc_q[paddr[3:2]] <= pwdata;  // RQ7 RQ18
      if (wrEn && paddr == OFF_RAMP)
        bufValid_q <= 1'b1;
      else if (start || (segEnd && bufValid_q))
        bufValid_q <= 1'b0;  // consumed into the current copy
    end
  end

  // control register; hardware drops enable on starvation
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      enable_q   <= 1'b0;
      combined_q <= 1'b0;
      clockSel_q <= RST_SEL;
      clockDiv_q <= RST_DIV;
    end else begin
      if (wrEn && paddr == OFF_CTRL) begin
        enable_q   <= pwdata[CTRL_EN];
        combined_q <= pwdata[CTRL_COMB];
        clockSel_q <= pwdata[CTRL_SEL +: SEL_W];
        clockDiv_q <= pwdata[CTRL_DIV +: DIV_W];
      end
      if (segEnd && !bufValid_q) enable_q <= 1'b0;  // RQ10
    end
  end

  // run state and current copy loading
  assign start = enable_q && !running_q && bufValid_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      running_q   <= 1'b0;
      loadCycle_q <= 1'b0;
      for (int i = 0; i < 4; i++) curDesc_q[i] <= RST_WORD;
    end else begin
      loadCycle_q <= start || segEnd;
      if (start || (segEnd && bufValid_q)) begin
        for (int i = 0; i < 4; i++) curDesc_q[i] <= bufDesc_q[i];  // RQ8
        running_q <= 1'b1;
      end else if (segEnd || (!enable_q && !(wrEn && paddr == OFF_CTRL))) begin
        running_q <= 1'b0;  // RQ10
      end
    end
  end

  // nested period counters, advanced on pwm ticks only
  assign ampWrap  = pwmTick && ampCnt_q >= ampPer;  // RQ1
  assign toneWrap = ampWrap && toneCnt_q >= toneLast;  // RQ3
  assign timeWrap = toneWrap && timeCnt_q >= durPer;  // RQ5
  assign segEnd   = running_q && timeWrap && nrCnt_q >= repCnt;  // RQ6
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ampCnt_q  <= '0;
      toneCnt_q <= '0;
      timeCnt_q <= '0;
      nrCnt_q   <= '0;
    end else if (!running_q || loadCycle_q) begin
      ampCnt_q  <= '0;
      toneCnt_q <= '0;
      timeCnt_q <= '0;
      nrCnt_q   <= '0;
    end else if (pwmTick) begin
      ampCnt_q <= ampWrap ? 16'h0000 : ampCnt_q + 1'b1;
      if (ampWrap) toneCnt_q <= toneWrap ? 17'h00000 : toneCnt_q + 1'b1;
      if (toneWrap) timeCnt_q <= timeWrap ? 16'h0000 : timeCnt_q + 1'b1;
      if (timeWrap) nrCnt_q <= segEnd ? 16'h0000 : nrCnt_q + 1'b1;
    end
  end

  // effective high time with ramp after each time period that does not end the segment
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      effHigh_q <= '0;
    end else if (loadCycle_q) begin
      effHigh_q <= fieldHi(curDesc_q[0]);  // RQ2
    end else if (timeWrap && !segEnd) begin
      unique case (rampDir)  // RQ17 RQ19
        RAMP_DOWN: effHigh_q <= (effHigh_q > stepAmt) ? effHigh_q - stepAmt : 16'h0000;
        RAMP_UP:   effHigh_q <= ({1'b0, effHigh_q} + {1'b0, stepAmt} > {1'b0, ampPer}) ?
                                ampPer : effHigh_q + stepAmt;
        default:   effHigh_q <= effHigh_q;
      endcase
    end
  end

  // output lines, updated on ticks, low when stopped
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      volumePwmOut <= 1'b0;
      pitchPwmOut  <= 1'b0;
    end else if (!running_q) begin
      volumePwmOut <= 1'b0;  // RQ20
      pitchPwmOut  <= 1'b0;
    end else if (pwmTick) begin  // RQ15
      if (combined_q) begin  // RQ16
        volumePwmOut <= (ampCnt_q <= effHigh_q) && (toneCnt_q <= {1'b0, toneHigh});
        pitchPwmOut  <= 1'b0;
      end else begin
        volumePwmOut <= ampCnt_q <= effHigh_q;  // RQ2
        pitchPwmOut  <= toneCnt_q <= {1'b0, toneHigh};  // RQ4
      end
    end
  end

  // sticky causes, set wins over write-one-clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cause_q            <= 3'h0;
      segmentDoneTrigger <= 1'b0;
    end else begin
      segmentDoneTrigger <= segEnd;  // RQ9
      for (int i = 0; i < 3; i++)
        if (wrEn && paddr == OFF_CAUSE && pwdata[i]) cause_q[i] <= 1'b0;
      if (segEnd) cause_q[CAUSE_DONE] <= 1'b1;  // RQ9
      if (segEnd && !bufValid_q) cause_q[CAUSE_STARV] <= 1'b1;  // RQ11
      if (pwmTick && loadCycle_q) cause_q[CAUSE_IF] <= 1'b1;  // RQ12
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_done_pulse;
    segEnd |=> segmentDoneTrigger && cause_q[CAUSE_DONE];
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not flagged"); // RQ9
  property p_trig_one;
    segmentDoneTrigger |=> !segmentDoneTrigger;
  endproperty
  a_trig_one: assert property (p_trig_one) else $error("trigger too long"); // RQ9
  property p_starve;
    segEnd && !bufValid_q |=> !running_q && cause_q[CAUSE_STARV] && !enable_q;
  endproperty
  a_starve: assert property (p_starve) else $error("starvation missed"); // RQ10
  property p_reload;
    segEnd && bufValid_q |=> running_q && curDesc_q[3] == $past(bufDesc_q[3]);
  endproperty
  a_reload: assert property (p_reload) else $error("reload missed"); // RQ8
  property p_quiet;
    !running_q |=> !volumePwmOut && !pitchPwmOut;
  endproperty
  a_quiet: assert property (p_quiet) else $error("output while stopped"); // RQ20
  property p_tick_only;
    running_q && $past(running_q) && !$past(pwmTick) |-> $stable(volumePwmOut);
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("change off tick"); // RQ15
  property p_amp_bound;
    running_q && !loadCycle_q |-> ampCnt_q <= ampPer;
  endproperty
  a_amp_bound: assert property (p_amp_bound) else $error("amp count past period"); // RQ1
  property p_tone_bound;
    running_q && !loadCycle_q |-> toneCnt_q <= toneLast;
  endproperty
  a_tone_bound: assert property (p_tone_bound) else $error("tone count past period"); // RQ3
  property p_ramp_sat;
    running_q && !loadCycle_q && rampDir == RAMP_UP |-> effHigh_q <= ampPer
      || effHigh_q == fieldHi(curDesc_q[0]);
  endproperty
  a_ramp_sat: assert property (p_ramp_sat) else $error("ramp past period"); // RQ19
  property p_comb_pitch;
    running_q && combined_q && $past(combined_q) && $past(pwmTick) |-> !pitchPwmOut;
  endproperty
  a_comb_pitch: assert property (p_comb_pitch) else $error("pitch in combined"); // RQ16

  // output, counter, copy, cause, clock and ramp checks
  property p_vol_first;
    running_q && pwmTick && !combined_q && ampCnt_q == 16'h0000 |=> volumePwmOut;
  endproperty
  a_vol_first: assert property (p_vol_first) else $error("volume low at period start"); // RQ2
  property p_vol_last;
    running_q && pwmTick && !combined_q && ampCnt_q == ampPer && effHigh_q < ampPer
      |=> !volumePwmOut;
  endproperty
  a_vol_last: assert property (p_vol_last) else $error("volume high at period end"); // RQ1
  property p_tone_first;
    running_q && pwmTick && !combined_q && toneCnt_q == 17'h00000 |=> pitchPwmOut;
  endproperty
  a_tone_first: assert property (p_tone_first) else $error("pitch low at tone start"); // RQ4
  property p_comb_gate;
    running_q && pwmTick && combined_q && toneCnt_q > {1'b0, toneHigh} |=> !volumePwmOut;
  endproperty
  a_comb_gate: assert property (p_comb_gate) else $error("combined high in tone low"); // RQ16
  property p_time_bound;
    running_q && !loadCycle_q |-> timeCnt_q <= durPer;
  endproperty
  a_time_bound: assert property (p_time_bound) else $error("time count past period"); // RQ5
  property p_rep_bound;
    running_q && !loadCycle_q |-> nrCnt_q <= repCnt;
  endproperty
  a_rep_bound: assert property (p_rep_bound) else $error("repeat count past limit"); // RQ6
  property p_cur_hold;
    !start && !(segEnd && bufValid_q) |=> $stable(curDesc_q[0]) && $stable(curDesc_q[3]);
  endproperty
  a_cur_hold: assert property (p_cur_hold) else $error("current copy changed"); // RQ7
  property p_trig_cause;
    segmentDoneTrigger |-> $past(segEnd);
  endproperty
  a_trig_cause: assert property (p_trig_cause) else $error("trigger without completion"); // RQ9
  property p_if_flag;
    pwmTick && loadCycle_q |=> cause_q[CAUSE_IF];
  endproperty
  a_if_flag: assert property (p_if_flag) else $error("interface underflow missed"); // RQ12
  property p_src_none;
    $past(clockSel_q) > SEL_MASTER |-> !pwmTick;
  endproperty
  a_src_none: assert property (p_src_none) else $error("tick from unused source"); // RQ13
  property p_mck_follow;
    $past(running_q) |-> (masterClockOut != $past(masterClockOut)) == pwmTick;
  endproperty
  a_mck_follow: assert property (p_mck_follow) else $error("master clock out off tick"); // RQ14
  property p_ramp_hold;
    running_q && !loadCycle_q && rampDir == RAMP_HOLD |=> $stable(effHigh_q);
  endproperty
  a_ramp_hold: assert property (p_ramp_hold) else $error("volume moved while held"); // RQ17
  property p_ramp_floor;
    timeWrap && !segEnd && !loadCycle_q && rampDir == RAMP_DOWN
      |=> effHigh_q <= $past(effHigh_q);
  endproperty
  a_ramp_floor: assert property (p_ramp_floor) else $error("down ramp rose"); // RQ19

  c_start:  cover property (start);
  c_reload: cover property (segEnd && bufValid_q);
  c_starve: cover property (segEnd && !bufValid_q);
  c_ifund:  cover property (pwmTick && loadCycle_q);
  c_ramp:   cover property (timeWrap && !segEnd && rampDir == RAMP_UP);
endmodule : pwm_sound_generator

// ---- amp_listener.sv ----
// Purpose: far-side model of the amplifier stage fed by the pwm lines
// Assumes: the lines are sampled on the system clock
// Notes:   lengths are counted in system clock cycles
`timescale 1ns/100ps
module amp_listener (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        clr,
  input  wire logic        volumePwmOut,
  input  wire logic        pitchPwmOut,
  input  wire logic        segmentDoneTrigger,
  output logic      [15:0] volRises,
  output logic      [15:0] pitchRises,
  output logic      [15:0] doneCount,
  output logic      [15:0] volHigh,
  output logic      [15:0] volPeriod
);
  logic        volPrev;
  logic        pitchPrev;
  logic [15:0] highRun;
  logic [15:0] periodRun;
  // edge counts and the last pulse and period lengths of the volume line
  always_ff @(posedge clock or posedge rst) begin
    if (rst || clr) begin
      {volPrev, pitchPrev, highRun, periodRun} <= '0;
      {volRises, pitchRises, doneCount, volHigh, volPeriod} <= '0;
    end else begin
      volPrev   <= volumePwmOut;
      pitchPrev <= pitchPwmOut;
      if (volumePwmOut && !volPrev) begin
        volRises  <= volRises + 16'h1;
        volPeriod <= periodRun + 16'h1;
        periodRun <= 16'h0;
        highRun   <= 16'h1;
      end else begin
        periodRun <= periodRun + 16'h1;
        highRun   <= highRun + 16'(volumePwmOut);
      end
      if (!volumePwmOut && volPrev) volHigh <= highRun;
      if (pitchPwmOut && !pitchPrev) pitchRises <= pitchRises + 16'h1;
      if (segmentDoneTrigger) doneCount <= doneCount + 16'h1;
    end
  end
endmodule : amp_listener

// ---- tb_top.sv ----
// Purpose: self-checking bench for one sound generator channel
// Assumes: clock sources toggle every clock, divider 0, so one tick per 2 clocks
// Notes:   registers are reached through an apb master task
`timescale 1ns/100ps
module tb_top;
  import sound_gen_pkg::*;
  localparam int TICK = 2;  // clocks per pwm tick
  logic        clock, rst, psel, penable, pwrite, pready, pslverr, clr, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  systemClockInputs;
  logic        masterClockIn, masterClockOut, volumePwmOut, pitchPwmOut, segmentDoneTrigger;
  logic [15:0] volRises, pitchRises, doneCount, volHigh, volPeriod;
  int          errTotal, nChecks;
  pwm_sound_generator pwm_sound_generator_inst (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .systemClockInputs(systemClockInputs),
    .masterClockIn(masterClockIn), .masterClockOut(masterClockOut),
    .volumePwmOut(volumePwmOut), .pitchPwmOut(pitchPwmOut),
    .segmentDoneTrigger(segmentDoneTrigger));
  amp_listener amp_listener_inst (.clock(clock), .rst(rst), .clr(clr),
    .volumePwmOut(volumePwmOut), .pitchPwmOut(pitchPwmOut),
    .segmentDoneTrigger(segmentDoneTrigger), .volRises(volRises), .pitchRises(pitchRises),
    .doneCount(doneCount), .volHigh(volHigh), .volPeriod(volPeriod));
  // system clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // interface clock sources, a rising edge every second clock
  always @(posedge clock) begin
    systemClockInputs <= ~systemClockInputs;
    masterClockIn     <= ~masterClockIn;
  end
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  // one comparison
  task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      errTotal++;
      summarize();
    end
    rd = prdata;
    e  = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  // load the buffered descriptor, ramp word last
  task automatic load(input logic [31:0] v, p, t, s);
    apb(1'b1, OFF_VOLUME, v);
    apb(1'b1, OFF_PITCH, p);
    apb(1'b1, OFF_DUR, t);
    apb(1'b1, OFF_RAMP, s);
  endtask : load
  // clear the listener and enable the channel
  task automatic start(input logic [31:0] ctrl);
    @(posedge clock) clr <= 1'b1;
    @(posedge clock) clr <= 1'b0;
    apb(1'b1, OFF_CTRL, ctrl);
  endtask : start
  // poll until the channel stops, then check idle outputs and causes
  task automatic waitStop();
    int n;
    for (n = 0; n < 200; n++) begin
      apb(1'b0, OFF_STATUS, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    if (n == 200) begin
      errTotal++;
      summarize();
    end
    check("idle lines", {masterClockOut, volumePwmOut, pitchPwmOut}, 32'h0);
    apb(1'b0, OFF_CAUSE, 32'h0);
    check("done and starved causes", rd & 32'h3, 32'h3);
    apb(1'b0, OFF_CTRL, 32'h0);
    check("enable cleared", rd & 32'h1, 32'h0);
    apb(1'b1, OFF_CAUSE, 32'h7);
    apb(1'b0, OFF_CAUSE, 32'h0);
    check("causes cleared", rd, 32'h0);
  endtask : waitStop
  // reset values and unmapped addresses
  task automatic tReset();
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      check("reset value", {e, rd}, 33'h0);
    end
    apb(1'b0, 8'h1C, 32'h0);
    check("unmapped read", {e, rd}, {1'b1, 32'h0});
    apb(1'b0, 8'h02, 32'h0);
    check("unaligned read", {e, rd}, {1'b1, 32'h0});
  endtask : tReset
  // the four descriptor words read back whole
  task automatic tReadback();
    load(32'h1234_5678, 32'h9ABC_DEF0, 32'h0F0F_F0F0, 32'hFFFF_FFFF);
    apb(1'b0, OFF_VOLUME, 32'h0);
    check("volume word", rd, 32'h1234_5678);
    apb(1'b0, OFF_PITCH, 32'h0);
    check("pitch word", rd, 32'h9ABC_DEF0);
    apb(1'b0, OFF_DUR, 32'h0);
    check("duration word", rd, 32'h0F0F_F0F0);
    apb(1'b0, OFF_RAMP, 32'h0);
    check("ramp word", rd, 32'hFFFF_FFFF);
  endtask : tReadback
  // one segment from system source 0, then starvation
  task automatic tSingle();
    load(32'h0001_0003, 32'h0, 32'h0003_0000, 32'h0);
    start(32'h0000_0001);
    waitStop();
    check("volume periods", volRises, 4 * 1 * 2 * (0 + 1));
    check("tone periods", pitchRises, 4 * 1);
    check("volume high", volHigh, TICK * (1 + 1));
    check("volume period", volPeriod, TICK * (3 + 1));
    check("done pulses", doneCount, 1);
  endtask : tSingle
  // buffer refilled while the first segment plays
  task automatic tDouble();
    load(32'h0001_0003, 32'h0, 32'h0003_0000, 32'h0);
    start(32'h0000_0001);
    load(32'h0002_0003, 32'h0, 32'h0001_0000, 32'h0);
    repeat (20) @(posedge clock);
    check("current copy drives", volHigh, TICK * (1 + 1));
    waitStop();
    check("done pulses", doneCount, 2);
    check("volume periods", volRises, 8 + 2 * 2);
    check("second high", volHigh, TICK * (2 + 1));
  endtask : tDouble
  // combined format from the master input with an upward ramp
  task automatic tRamp();
    load(32'h0000_0007, 32'h0, 32'h0001_0000, 32'h0002_0002);
    start(32'h0000_0043);
    waitStop();
    check("pitch line idle", pitchRises, 0);
    check("combined pulses", volRises, 2);
    check("ramped high", volHigh, TICK * (0 + 1 + 2));
  endtask : tRamp
  // reset, then the scenarios in turn
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, clr} = '0;
    {systemClockInputs, masterClockIn, errTotal, nChecks} = '0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    tReset();
    tReadback();
    tSingle();
    tDouble();
    tRamp();
    summarize();
  end
endmodule : tb_top
